// >>> logic/adcctl_defs.vh
// Function
// - The converter is enabled only while control bit 7 is one.
// - Writing one to control bit 6 starts a conversion and the bit clears itself when conversion begins.
// - Control bit 6 reads zero while a conversion runs and one once it has completed.
// - Control bits 5 to 2 select the input: 0-7 port B inputs, 8 port A pin 3, 9 port A pin 4, 15 the bandgap, others reserved.
// - Mode bits 7 to 5 select 8, 9 or 10 bit resolution with codes 0, 1 and 2.
// - At 8 bits the whole result sits in high result bits 7 to 0.
// - At 9 bits the result is the high result byte followed by low result bit 7.
// - At 10 bits the result is the high result byte followed by low result bits 7 and 6.
// - Mode bits 4 to 1 divide the system clock by two to the power of the code's low three bits, up to 128.
// - The high result register is read-only and holds result bits 9 to 2 with the MSB in bit 7.
// - Low result bits 7 and 6 are read-only result bits 1 and 0, bits 5 to 0 are reserved.
`ifndef ADCCTL_DEFS_VH
`define ADCCTL_DEFS_VH
`define ADCCTL_OFS_CTRL   8'h20
`define ADCCTL_OFS_MODE   8'h21
`define ADCCTL_OFS_RESH   8'h22
`define ADCCTL_OFS_RESL   8'h23
`define ADCCTL_OFS_IRQST  8'h24
`define ADCCTL_OFS_IRQMSK 8'h25
`define ADCCTL_CTRL_EN    7
`define ADCCTL_CTRL_START 6
`define ADCCTL_CTRL_RST   8'h00
`define ADCCTL_MODE_RST   8'h00
`define ADCCTL_RES_8      3'h0
`define ADCCTL_RES_9      3'h1
`define ADCCTL_RES_10     3'h2
`define ADCCTL_CHAN_BG    4'hf
`define ADCCTL_SAMPLE_CLKS 4'h2
`endif

// >>> logic/adcctl_top.v
`timescale 1ns/100ps
`default_nettype none
`include "adcctl_defs.vh"

module adcctl_top #(
    parameter ADDR_W = 8
) (
    // Clock and reset
    input  wire              sys_clk,
    input  wire              srst,
    // AXI4-Lite write address and data
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    // AXI4-Lite read
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // Analog core
    output reg               adc_enable,
    output reg  [3:0]        adc_channel,
    output reg               adc_conv_clk_en,
    output reg               adc_sample,
    input  wire              adc_bit,
    // Interrupt
    output reg               irq
);

    // Sequencer states, one-hot
    localparam ST_IDLE   = 3'b001;
    localparam ST_SAMPLE = 3'b010;
    localparam ST_CONV   = 3'b100;

    // Resolution code to bit count; reserved codes fall back to 10
    function [3:0] res_bits;
        input [2:0] code;
        begin
            case (code)
                `ADCCTL_RES_8: res_bits = 4'h8;
                `ADCCTL_RES_9: res_bits = 4'h9;
                default:       res_bits = 4'ha;
            endcase
        end
    endfunction

    // Register index in the upper address bits; the two low bits pick a byte lane
    function [ADDR_W-1:0] reg_index;
        input [ADDR_W-1:0] addr;
        begin
            reg_index = {2'b00, addr[ADDR_W-1:2]};
        end
    endfunction

    // Software visible registers
    reg              en_r;
    reg [3:0]        chan_r;
    reg              done_r;
    reg [2:0]        res_r;
    reg [3:0]        clksel_r;
    reg [7:0]        resh_r;
    reg [1:0]        resl_r;
    reg [1:0]        ist_r;
    reg [1:0]        imsk_r;
    // Sequencer state, divider, bit counter and shift register
    reg [2:0]        state_r;
    reg [6:0]        div_r;
    reg [3:0]        cnt_r;
    reg [9:0]        sar_r;
    // Write channel holding registers
    reg [ADDR_W-1:0] awaddr_r;
    reg [31:0]       wdata_r;
    reg              aw_have_r;
    reg              w_have_r;

    // Write decode; a register changes on the cycle its response is launched
    wire       wr_go     = aw_have_r && w_have_r && !s_axi_bvalid;
    wire       wr_ctrl   = wr_go && awaddr_r == `ADCCTL_OFS_CTRL;
    wire       wr_mode   = wr_go && awaddr_r == `ADCCTL_OFS_MODE;
    wire       wr_irqst  = wr_go && awaddr_r == `ADCCTL_OFS_IRQST;
    wire       wr_irqmsk = wr_go && awaddr_r == `ADCCTL_OFS_IRQMSK;
    wire       wr_mapped = awaddr_r >= `ADCCTL_OFS_CTRL && awaddr_r <= `ADCCTL_OFS_IRQMSK;
    // A start needs enable in the same write, so a stale enable cannot fire it
    wire       start_req = wr_ctrl && wdata_r[`ADCCTL_CTRL_START];
    wire       start     = start_req && wdata_r[`ADCCTL_CTRL_EN]
                           && state_r == ST_IDLE;
    wire       start_off = start_req && !wdata_r[`ADCCTL_CTRL_EN];
    // Divider tick: code n divides sysclk by 2 to the power of its low three bits, code 0 ticks every cycle
    wire [7:0] div_mask = (8'h01 << clksel_r[2:0]) - 8'h01;
    wire       tick     = ({1'b0, div_r} & div_mask) == (div_mask & 8'h7f)
                          || clksel_r == 4'h0;
    // Bit counter reaches one on the final shift
    wire       conv_end = state_r == ST_CONV && tick && cnt_r == 4'h1;
    // Last shift of a conversion that was not aborted by a disable
    wire       conv_done = conv_end && en_r;
    wire [9:0] sar_nxt  = {sar_r[8:0], adc_bit};
    reg  [9:0] aligned;
    // Read mux outputs; unmapped indices answer zero with an error
    reg  [31:0] rd_word;
    reg         rd_err;

    // Left-align the finished word so the MSB lands in high result bit 7
    always @* begin
        case (res_bits(res_r))
            4'h8:    aligned = {sar_nxt[7:0], 2'b00};
            4'h9:    aligned = {sar_nxt[8:0], 1'b0};
            default: aligned = sar_nxt[9:0];
        endcase
    end

    // Write address capture; holds one register index until its response is launched
    always @(posedge sys_clk) begin
        if (srst) begin
            aw_have_r     <= 1'b0;
            awaddr_r      <= {ADDR_W{1'b0}};
            s_axi_awready <= 1'b0;
        end else begin
            // Ready pulses for one cycle so a held valid is taken exactly once
            s_axi_awready <= !aw_have_r && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r     <= 1'b1;
                awaddr_r      <= reg_index(s_axi_awaddr);
                s_axi_awready <= 1'b0;
            end
            if (wr_go)
                aw_have_r <= 1'b0;
        end
    end

    // Write data capture; only byte lane 0 carries register data
    always @(posedge sys_clk) begin
        if (srst) begin
            w_have_r     <= 1'b0;
            wdata_r      <= 32'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_have_r && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r     <= 1'b1;
                wdata_r      <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0;
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
                w_have_r <= 1'b0;
        end
    end

    // Write response; an index outside the map answers with an error
    always @(posedge sys_clk) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control register fields; bits 1:0 are dropped, software keeps them zero
    always @(posedge sys_clk) begin
        if (srst) begin
            en_r   <= 1'b0;
            chan_r <= 4'h0;
        end else if (wr_ctrl) begin
            en_r   <= wdata_r[`ADCCTL_CTRL_EN];
            chan_r <= wdata_r[5:2];
        end
    end

    // Mode register; a change mid-conversion takes effect at the next tick
    always @(posedge sys_clk) begin
        if (srst) begin
            res_r    <= 3'h0;
            clksel_r <= 4'h0;
        end else if (wr_mode) begin
            res_r    <= wdata_r[7:5];
            clksel_r <= wdata_r[4:1];
        end
    end

    // Interrupt mask
    always @(posedge sys_clk) begin
        if (srst)
            imsk_r <= 2'h0;
        else if (wr_irqmsk)
            imsk_r <= wdata_r[1:0];
    end

    // A start while busy is dropped; software polls the done bit first
    // Conversion sequencer: sample, then one bit per divided clock tick
    always @(posedge sys_clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            done_r  <= 1'b1;
            div_r   <= 7'h0;
            cnt_r   <= 4'h0;
            sar_r   <= 10'h0;
            resh_r  <= 8'h0;
            resl_r  <= 2'h0;
        end else begin
            // Divider is parked at zero so the first tick is a full period away
            div_r <= (state_r == ST_IDLE) ? 7'h0 : div_r + 7'h1;
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        done_r  <= 1'b0;
                        cnt_r   <= `ADCCTL_SAMPLE_CLKS;
                        sar_r   <= 10'h0;
                        state_r <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    // Core holds the input for a fixed number of ticks
                    if (!en_r) begin
                        done_r  <= 1'b1;
                        state_r <= ST_IDLE;
                    end else if (tick) begin
                        if (cnt_r == 4'h1) begin
                            cnt_r   <= res_bits(res_r);
                            state_r <= ST_CONV;
                        end else begin
                            cnt_r <= cnt_r - 4'h1;
                        end
                    end
                end
                ST_CONV: begin
                    if (!en_r) begin
                        // Disable aborts; previous result stays
                        done_r  <= 1'b1;
                        state_r <= ST_IDLE;
                    end else if (tick) begin
                        sar_r <= sar_nxt;
                        cnt_r <= cnt_r - 4'h1;
                        if (conv_end) begin
                            resh_r   <= aligned[9:2];
                            resl_r   <= aligned[1:0];
                            done_r   <= 1'b1;
                            state_r  <= ST_IDLE;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Interrupt status: write one to clear, an event in the same cycle wins
    always @(posedge sys_clk) begin
        if (srst) begin
            ist_r <= 2'h0;
        end else begin
            if (wr_irqst)
                ist_r <= ist_r & ~wdata_r[1:0];
            // A start written with enable clear is reported so software can see the lost request
            if (start_off)
                ist_r[1] <= 1'b1;
            if (conv_done)
                ist_r[0] <= 1'b1;
        end
    end

    // Read data mux, decoded straight from the offered address
    always @* begin
        rd_word = 32'h0;
        rd_err  = 1'b0;
        case (reg_index(s_axi_araddr))
            `ADCCTL_OFS_CTRL:
                rd_word = {24'h0, en_r, done_r, chan_r, 2'b00};
            // Mode register is write-only and reads zero
            `ADCCTL_OFS_MODE:   rd_word = 32'h0;
            `ADCCTL_OFS_RESH:   rd_word = {24'h0, resh_r};
            `ADCCTL_OFS_RESL:   rd_word = {24'h0, resl_r, 6'h00};
            `ADCCTL_OFS_IRQST:  rd_word = {30'h0, ist_r};
            `ADCCTL_OFS_IRQMSK: rd_word = {30'h0, imsk_r};
            default:            rd_err  = 1'b1;
        endcase
    end

    // Read channel, one response per address; data held until taken
    always @(posedge sys_clk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_err ? 2'h2 : 2'h0;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Enable and channel to the analog core, one cycle behind the register
    always @(posedge sys_clk) begin
        if (srst) begin
            adc_enable  <= 1'b0;
            adc_channel <= 4'h0;
        end else begin
            adc_enable  <= en_r;
            adc_channel <= chan_r;
        end
    end

    // Sequencer strobes; the core sees a tick only while a conversion runs
    always @(posedge sys_clk) begin
        if (srst) begin
            adc_conv_clk_en <= 1'b0;
            adc_sample      <= 1'b0;
        end else begin
            adc_conv_clk_en <= tick && state_r != ST_IDLE;
            adc_sample      <= state_r == ST_SAMPLE;
        end
    end

    // Level interrupt, high while any unmasked status bit stands
    always @(posedge sys_clk) begin
        if (srst)
            irq <= 1'b0;
        else
            irq <= |(ist_r & imsk_r);
    end

endmodule
`default_nettype wire

// >>> testbench/adcctl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module adcctl_asserts #(parameter ADDR_W = 8) (
    // Clock, reset and bus
    input wire logic              sys_clk, srst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr,
    input wire logic [31:0]       s_axi_wdata, s_axi_rdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic [1:0]        s_axi_bresp, s_axi_rresp,
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic s_axi_rvalid, s_axi_rready,
    // Core and interrupt
    input wire logic [3:0]        adc_channel,
    input wire logic adc_enable, adc_conv_clk_en, adc_sample, adc_bit, irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic       aw_bad_r, ar_bad_r, seen_r;
    logic [3:0] chan_r, code_r;
    logic [8:0] gap_r;
    wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire ctrl_go = wr_go && s_axi_awaddr[7:2] == 6'h20;
    // Capture access targets; seen_r drops on control writes so gaps across runs are not judged
    always @(posedge sys_clk) begin
        if (s_axi_awvalid && s_axi_awready)
            aw_bad_r <= s_axi_awaddr[7:2] < 6'h20 || s_axi_awaddr[7:2] > 6'h25;
        if (s_axi_arvalid && s_axi_arready)
            ar_bad_r <= s_axi_araddr[7:2] < 6'h20 || s_axi_araddr[7:2] > 6'h25;
        if (ctrl_go)
            chan_r <= s_axi_wdata[5:2];
        if (srst)
            code_r <= 4'h0;
        else if (wr_go && s_axi_awaddr[7:2] == 6'h21)
            code_r <= s_axi_wdata[4:1];
        gap_r <= adc_conv_clk_en ? 9'h001 : gap_r + {8'h00, gap_r != 9'h1ff};
        seen_r <= (srst || ctrl_go) ? 1'b0 : (seen_r || adc_conv_clk_en);
    end
    sequence s_ctrl_wr(logic on);
        ctrl_go && s_axi_wdata[7] == on;
    endsequence
    a_enable_on: assert property (s_ctrl_wr(1'b1) |-> ##[1:4] adc_enable)
        else $error("enable missing");
    a_enable_off: assert property (s_ctrl_wr(1'b0) |-> ##[1:4] !adc_enable)
        else $error("enable stuck");
    a_chan_follow: assert property (ctrl_go |-> ##[1:4] adc_channel == chan_r)
        else $error("channel wrong");
    a_off_quiet: assert property (!adc_enable && !$past(adc_enable)
        && !$past(adc_enable, 2) |-> !adc_sample && !adc_conv_clk_en) else $error("busy when off");
    a_start_off: assert property (s_ctrl_wr(1'b0) ##0 s_axi_wdata[6]
        |-> ##1 !adc_sample [*8]) else $error("start not ignored");
    a_sample_on: assert property ($rose(adc_sample) |-> adc_enable)
        else $error("sample while off");
    a_tick_gap: assert property (adc_conv_clk_en && seen_r
        |-> gap_r == 9'h001 << code_r[2:0]) else $error("tick spacing");
    a_bresp_bad: assert property (s_axi_bvalid && aw_bad_r |-> s_axi_bresp == 2'b10)
        else $error("bresp wrong");
    a_rresp_bad: assert property (s_axi_rvalid && ar_bad_r
        |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("rresp wrong");
    a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid stuck");
    a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid stuck");
endmodule
bind adcctl_top adcctl_asserts #(.ADDR_W(ADDR_W)) chk (.*);
`default_nettype wire

// >>> testbench/adcctl_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module adcctl_core_model (
    input wire logic       sys_clk,
    input wire logic       adc_enable,
    input wire logic [3:0] adc_channel,
    output logic           adc_bit
);
    initial adc_bit = 1'b0;
    // Input 0 sits at ground, all others at full scale; an idle core toggles, never stale
    // Pins act as pure analog inputs, as with their digital input switched off
    always @(posedge sys_clk)
        adc_bit <= adc_enable ? (adc_channel != 4'h0) : ~adc_bit;
endmodule
`default_nettype wire

// >>> testbench/adcctl_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "adcctl_defs.vh"
module adcctl_bench;
    localparam logic [7:0] A_CTRL = `ADCCTL_OFS_CTRL << 2, A_MODE = `ADCCTL_OFS_MODE << 2;
    localparam logic [7:0] A_RESH = `ADCCTL_OFS_RESH << 2, A_RESL = `ADCCTL_OFS_RESL << 2;
    localparam logic [7:0] A_STAT = `ADCCTL_OFS_IRQST << 2, A_MASK = `ADCCTL_OFS_IRQMSK << 2;
    logic        sys_clk = 1'b0, srst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rd_v;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf, adc_channel, ch;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic adc_enable, adc_conv_clk_en, adc_sample, adc_bit, irq;
    int   err_count = 0, compares = 0, cycles = 0;
    adcctl_top #(.ADDR_W(8)) DUT (.*);
    adcctl_core_model core (.*);
    initial forever #5 sys_clk = ~sys_clk;
    task automatic check(input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Slowest conversion is about 1600 cycles; the whole run stays far below this ceiling
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_count++;
            final_report();
        end
    end
    // Address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, d);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd_v = s_axi_rdata[7:0];
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        rd(A_CTRL); check(rd_v, 8'h40);
        rd(A_RESH); check(rd_v, 8'h00);
        rd(A_RESL); check(rd_v, 8'h00);
        rd(8'hfc); check({rd_v, rs}, 10'h002);
        wr(8'hfc, 8'h00); check(rs, 2'b10);
        $display("test reset and decode done");
        wr(A_CTRL, 8'h40);
        rd(A_CTRL); check(rd_v, 8'h40);
        rd(A_STAT); check(rd_v[1], 1'b1);
        wr(A_MASK, 8'h03);
        repeat (3) @(posedge sys_clk);
        check(irq, 1'b1);
        wr(A_STAT, 8'h02);
        repeat (3) @(posedge sys_clk);
        check(irq, 1'b0);
        $display("test ignored start and interrupt done");
        // Divider codes 0 to 7, resolution stepping through 8, 9 and 10 bits
        for (int i = 0; i < 8; i++) begin
            ch = 4'(32'h59f98720 >> (4 * i));
            wr(A_MODE, {3'(i % 3), 4'(i), 1'b0});
            wr(A_CTRL, {2'b10, ch, 2'b00});
            wr(A_CTRL, {2'b11, ch, 2'b00});
            rd(A_CTRL);
            if (i > 1) check(rd_v, {2'b10, ch, 2'b00});
            for (int n = 0; n < 600 && rd_v[6] !== 1'b1; n++) rd(A_CTRL);
            check(rd_v, {2'b11, ch, 2'b00});
            rd(A_RESH); check(rd_v, ch != 0 ? 8'hff : 8'h00);
            rd(A_RESL); check(rd_v, ch != 0 ? 8'(8'hc0 << (2 - i % 3)) : 8'h00);
        end
        rd(A_STAT); check(rd_v[0], 1'b1);
        check(irq, 1'b1);
        wr(A_STAT, 8'h01);
        repeat (3) @(posedge sys_clk);
        check(irq, 1'b0);
        wr(A_MODE, 8'h0e);
        wr(A_CTRL, 8'hc4);
        wr(A_CTRL, 8'h04);
        rd(A_CTRL); check(rd_v, 8'h44);
        $display("test conversions done");
        final_report();
    end
endmodule
`default_nettype wire
